/* rtl/pprf_map.svh */
// register map, field positions, reset values and timing counts
`ifndef PPRF_MAP_SVH
`define PPRF_MAP_SVH

// byte offsets, one aligned 32-bit word each
`define PPRF_CTRL_OFS 6'h00
`define PPRF_LSFLT_OFS 6'h04
`define PPRF_HSFLT_OFS 6'h08
`define PPRF_MAXF_OFS 6'h0C
`define PPRF_GNUM_OFS 6'h10
`define PPRF_GDEN_OFS 6'h14
`define PPRF_STAT_OFS 6'h18
`define PPRF_REFC_OFS 6'h1C
`define PPRF_ENCP_OFS 6'h20
`define PPRF_FREQ_OFS 6'h24

// control word fields
`define PPRF_CTRL_MODE_LSB 0
`define PPRF_CTRL_SRC_LSB 4
`define PPRF_CTRL_GRP_BIT 8
`define PPRF_CTRL_FORM_LSB 12
`define PPRF_CTRL_DIR_BIT 16
`define PPRF_CTRL_MASK 32'h0001_31FF

// status word fields
`define PPRF_STAT_ERR_BIT 0
`define PPRF_STAT_ACT_BIT 1

// mode and source codes
`define PPRF_MODE_POSITION 4'h1
`define PPRF_SRC_PULSE 4'h0

// reset values
`define PPRF_CTRL_RST 32'h0000_0000
`define PPRF_LSFLT_RST 16'h001E
`define PPRF_HSFLT_RST 16'h0005
`define PPRF_MAXF_RST 32'h0000_1F40
`define PPRF_GEAR_RST 32'h0000_0001

// timing
`define PPRF_CLK_MHZ 100
`define PPRF_CLK_NS 10
`define PPRF_FILT_STEP_NS 25
`define PPRF_FREQ_WIN_US 1000
`define PPRF_LS_MAX_KPPS 32'd200
`define PPRF_HS_MAX_KPPS 32'd8000

`endif

/* rtl/pprf_pkg.sv */
// types shared by the pulse position reference front end
package pprf_pkg;

    typedef enum logic [1:0] {
        PPRF_FORM_PD_POS = 2'h0,
        PPRF_FORM_PD_NEG = 2'h1,
        PPRF_FORM_QUAD = 2'h2,
        PPRF_FORM_CWCCW = 2'h3
    } pprf_form_t;

    typedef struct packed {
        logic pulse;
        logic dir;
    } pprf_pins_t;

    typedef struct packed {
        logic en;
        logic up;
    } pprf_step_t;

endpackage

/* rtl/pprf_top.sv */
// pulse position reference input: pin filters, pulse decoder, gear, overrate check
`timescale 1ns/1ps
`include "pprf_map.svh"

module pprf_top #(
    parameter int unsigned FREQ_WIN_CYC = `PPRF_FREQ_WIN_US * `PPRF_CLK_MHZ
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ls_pulse,
    input wire logic ls_direction,
    input wire logic high_speed_pulse_pos,
    input wire logic high_speed_pulse_neg,
    input wire logic high_speed_direction_pos,
    input wire logic high_speed_direction_neg,
    input wire logic position_ref_inhibit_input,
    output logic position_mode_active,
    output logic pulse_input_overrate_error,
    output logic ref_step_valid,
    output logic ref_step_up,
    output logic [31:0] ref_count,
    output logic [31:0] enc_position
);

    // ----------------------------------------
    // bus slave
    // ----------------------------------------

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [31:0] ctrl_ff;
    logic [15:0] ls_flt_ff;
    logic [15:0] hs_flt_ff;
    logic [31:0] maxf_ff;
    logic [31:0] gnum_ff;
    logic [31:0] gden_ff;
    logic err_ff;
    logic [31:0] freq_ff;
    logic [31:0] refc_ff;
    logic [31:0] enc_ff;

    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ack_ff;
    wire sel_ctrl = avs_address == `PPRF_CTRL_OFS;
    wire sel_ls = avs_address == `PPRF_LSFLT_OFS;
    wire sel_hs = avs_address == `PPRF_HSFLT_OFS;
    wire sel_maxf = avs_address == `PPRF_MAXF_OFS;
    wire sel_gnum = avs_address == `PPRF_GNUM_OFS;
    wire sel_gden = avs_address == `PPRF_GDEN_OFS;
    wire sel_stat = avs_address == `PPRF_STAT_OFS;
    wire sel_refc = avs_address == `PPRF_REFC_OFS;
    wire sel_encp = avs_address == `PPRF_ENCP_OFS;
    wire sel_freq = avs_address == `PPRF_FREQ_OFS;

    // one wait cycle per access keeps the read mux off the bus path
    assign avs_waitrequest = req & ~ack_ff;
    assign avs_readdata = rdata_ff;

    wire [31:0] stat_word = {30'h0000_0000, position_mode_active, err_ff};
    wire [31:0] rd_mux =
        sel_ctrl ? ctrl_ff :
        sel_ls ? {16'h0000, ls_flt_ff} :
        sel_hs ? {16'h0000, hs_flt_ff} :
        sel_maxf ? maxf_ff :
        sel_gnum ? gnum_ff :
        sel_gden ? gden_ff :
        sel_stat ? stat_word :
        sel_refc ? refc_ff :
        sel_encp ? enc_ff :
        sel_freq ? freq_ff : 32'h0000_0000;

    wire [31:0] nxt_ctrl = merge(ctrl_ff, avs_writedata, avs_byteenable) & `PPRF_CTRL_MASK;
    wire [31:0] ls_word = merge({16'h0000, ls_flt_ff}, avs_writedata, avs_byteenable);
    wire [31:0] hs_word = merge({16'h0000, hs_flt_ff}, avs_writedata, avs_byteenable);

    // handshake and read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req & ~ack_ff;
            rdata_ff <= (avs_read & ~ack_ff) ? rd_mux : rdata_ff;
        end
    end

    // configuration registers, written at the edge after the wait cycle, when the access is accepted
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= `PPRF_CTRL_RST;
            ls_flt_ff <= `PPRF_LSFLT_RST;
            hs_flt_ff <= `PPRF_HSFLT_RST;
            maxf_ff <= `PPRF_MAXF_RST;
            gnum_ff <= `PPRF_GEAR_RST;
            gden_ff <= `PPRF_GEAR_RST;
        end else if (wr_go) begin
            if (sel_ctrl) ctrl_ff <= nxt_ctrl;
            if (sel_ls) ls_flt_ff <= ls_word[15:0];
            if (sel_hs) hs_flt_ff <= hs_word[15:0];
            if (sel_maxf) maxf_ff <= merge(maxf_ff, avs_writedata, avs_byteenable);
            if (sel_gnum) gnum_ff <= merge(gnum_ff, avs_writedata, avs_byteenable);
            if (sel_gden) gden_ff <= merge(gden_ff, avs_writedata, avs_byteenable);
        end
    end

    // ----------------------------------------
    // control decode
    // ----------------------------------------

    wire [3:0] mode = ctrl_ff[`PPRF_CTRL_MODE_LSB +: 4];
    wire [3:0] src = ctrl_ff[`PPRF_CTRL_SRC_LSB +: 4];
    wire grp_hs = ctrl_ff[`PPRF_CTRL_GRP_BIT];
    wire dir_inv = ctrl_ff[`PPRF_CTRL_DIR_BIT];
    pprf_pkg::pprf_form_t form;
    assign form = pprf_pkg::pprf_form_t'(ctrl_ff[`PPRF_CTRL_FORM_LSB +: 2]);

    wire active = (mode == `PPRF_MODE_POSITION) && (src == `PPRF_SRC_PULSE);

    // ----------------------------------------
    // pin filters
    // ----------------------------------------

    // differential pair: reads high only when the pos leg is high and the neg leg low, agreeing legs read low
    wire hs_pulse_rx = high_speed_pulse_pos & ~high_speed_pulse_neg;
    wire hs_dir_rx = high_speed_direction_pos & ~high_speed_direction_neg;

    // setting times 25 ns, rounded up to whole clocks
    wire [21:0] ls_ns = 22'(ls_flt_ff) * 22'(`PPRF_FILT_STEP_NS);
    wire [21:0] hs_ns = 22'(hs_flt_ff) * 22'(`PPRF_FILT_STEP_NS);
    wire [21:0] ls_cyc = (ls_ns + 22'(`PPRF_CLK_NS - 1)) / 22'(`PPRF_CLK_NS);
    wire [21:0] hs_cyc = (hs_ns + 22'(`PPRF_CLK_NS - 1)) / 22'(`PPRF_CLK_NS);
    // a zero setting still costs one register stage
    wire [21:0] ls_thr = (ls_cyc == 22'h0) ? 22'h1 : ls_cyc;
    wire [21:0] hs_thr = (hs_cyc == 22'h0) ? 22'h1 : hs_cyc;

    // channels 0,1 low-speed pair, 2,3 high-speed pair
    wire [3:0] raw = {hs_dir_rx, hs_pulse_rx, ls_direction, ls_pulse};
    logic [3:0] filt;

    // level must hold for the whole filter time to pass
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flt
            logic out_ff;
            logic [21:0] cnt_ff;
            wire [21:0] thr = (gi < 2) ? ls_thr : hs_thr;
            wire [21:0] cnt_inc = cnt_ff + 22'h1;
            wire hit = cnt_inc >= thr;
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    out_ff <= 1'b0;
                    cnt_ff <= 22'h0;
                end else if (raw[gi] == out_ff) begin
                    cnt_ff <= 22'h0;
                end else if (hit) begin
                    out_ff <= raw[gi];
                    cnt_ff <= 22'h0;
                end else begin
                    cnt_ff <= cnt_inc;
                end
            end
            assign filt[gi] = out_ff;
        end
    endgenerate

    // ----------------------------------------
    // pulse decoder
    // ----------------------------------------

    pprf_pkg::pprf_pins_t cur;
    pprf_pkg::pprf_pins_t prv_ff;
    assign cur.pulse = grp_hs ? filt[2] : filt[0];
    assign cur.dir = grp_hs ? filt[3] : filt[1];

    wire p_rise = cur.pulse & ~prv_ff.pulse;
    wire d_rise = cur.dir & ~prv_ff.dir;
    wire a_chg = cur.pulse ^ prv_ff.pulse;
    wire b_chg = cur.dir ^ prv_ff.dir;

    // A leading B when old A matches new B
    wire quad_en = a_chg ^ b_chg;
    wire quad_up = ~(prv_ff.pulse ^ cur.dir);

    pprf_pkg::pprf_step_t raw_step;
    always_comb begin
        raw_step = '0;
        case (form)
            pprf_pkg::PPRF_FORM_PD_POS: begin
                raw_step.en = p_rise;
                raw_step.up = cur.dir;
            end
            pprf_pkg::PPRF_FORM_PD_NEG: begin
                raw_step.en = p_rise;
                raw_step.up = ~cur.dir;
            end
            pprf_pkg::PPRF_FORM_QUAD: begin
                raw_step.en = quad_en;
                raw_step.up = quad_up;
            end
            pprf_pkg::PPRF_FORM_CWCCW: begin
                // simultaneous edges cancel out
                raw_step.en = p_rise ^ d_rise;
                raw_step.up = p_rise;
            end
            default: begin
                raw_step = '0;
            end
        endcase
    end

    // inhibit drops the step, count holds
    wire step_go = raw_step.en & active & ~position_ref_inhibit_input;
    // direction setting flips the sense of every form
    wire step_up = raw_step.up ^ dir_inv;
    wire [31:0] nxt_refc = step_up ? refc_ff + 32'h1 : refc_ff - 32'h1;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prv_ff <= '0;
            refc_ff <= 32'h0000_0000;
            ref_step_valid <= 1'b0;
            ref_step_up <= 1'b0;
        end else begin
            prv_ff <= cur;
            refc_ff <= step_go ? nxt_refc : refc_ff;
            ref_step_valid <= step_go;
            ref_step_up <= step_go ? step_up : ref_step_up;
        end
    end

    // ----------------------------------------
    // electronic gear
    // ----------------------------------------

    // encoder units = count * num / den, zero den read as one
    wire [31:0] den_eff = (gden_ff == 32'h0) ? 32'h1 : gden_ff;
    wire signed [63:0] prod = $signed({{32{refc_ff[31]}}, refc_ff}) * $signed({32'h0, gnum_ff});
    wire signed [63:0] quot = prod / $signed({32'h0, den_eff});

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enc_ff <= 32'h0000_0000;
        end else begin
            enc_ff <= quot[31:0];
        end
    end

    // ----------------------------------------
    // pulse rate check
    // ----------------------------------------

    // window is one millisecond, so a window count reads as kpps
    logic [31:0] win_ff;
    logic [31:0] ev_ff;
    wire rise_ev = (form == pprf_pkg::PPRF_FORM_CWCCW) ? (p_rise | d_rise) : p_rise;
    wire win_end = win_ff == 32'(FREQ_WIN_CYC - 1);
    wire [31:0] ev_nxt = rise_ev ? ev_ff + 32'h1 : ev_ff;
    wire [31:0] grp_max = grp_hs ? `PPRF_HS_MAX_KPPS : `PPRF_LS_MAX_KPPS;
    wire [31:0] limit = (maxf_ff < grp_max) ? maxf_ff : grp_max;

    // running count checked so the error shows mid-window
    wire over = active & (ev_nxt > limit);
    wire err_clr = wr_go & sel_stat & avs_writedata[`PPRF_STAT_ERR_BIT] & avs_byteenable[0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            win_ff <= 32'h0000_0000;
            ev_ff <= 32'h0000_0000;
            freq_ff <= 32'h0000_0000;
        end else if (win_end) begin
            win_ff <= 32'h0000_0000;
            ev_ff <= 32'h0000_0000;
            freq_ff <= ev_nxt;
        end else begin
            win_ff <= win_ff + 32'h1;
            ev_ff <= ev_nxt;
        end
    end

    // sticky error, set wins over clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= over | (err_ff & ~err_clr);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    logic act_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            act_ff <= 1'b0;
        end else begin
            act_ff <= active;
        end
    end

    assign position_mode_active = act_ff;
    assign pulse_input_overrate_error = err_ff;
    assign ref_count = refc_ff;
    assign enc_position = enc_ff;

endmodule

/* testbench/pprf_checker.sv */
// concurrent checks on the pulse reference front end ports
`timescale 1ns/1ps
`include "pprf_map.svh"
module pprf_checker #(
    parameter int unsigned FREQ_WIN_CYC = 100000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic position_ref_inhibit_input,
    input wire logic position_mode_active,
    input wire logic pulse_input_overrate_error,
    input wire logic ref_step_valid,
    input wire logic ref_step_up,
    input wire logic [31:0] ref_count
);
    // ------------------------------------------------------------
    // helpers and sequences
    // ------------------------------------------------------------
    wire logic req;
    wire logic stat_clr;
    assign req = avs_read | avs_write;
    // error clear only through lane 0 of an accepted status write
    assign stat_clr = avs_write & ~avs_waitrequest & avs_writedata[0] & avs_byteenable[0]
        & (avs_address == `PPRF_STAT_OFS);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence wait_cyc;
        req && avs_waitrequest;
    endsequence
    sequence inhib_held;
        position_ref_inhibit_input [*3];
    endsequence
    sequence idle_held;
        !position_mode_active [*2];
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    wait_one_a: assert property (wait_cyc |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
    wait_first_a: assert property (req && !avs_waitrequest |-> $past(avs_waitrequest))
        else $error("bus answered without a wait cycle");
    idle_nowait_a: assert property (!req |-> !avs_waitrequest)
        else $error("wait raised with no request");
    step_up_a: assert property (ref_step_valid && ref_step_up |->
        ref_count == $past(ref_count) + 32'h1) else $error("up step not plus one");
    step_down_a: assert property (ref_step_valid && !ref_step_up |->
        ref_count == $past(ref_count) - 32'h1) else $error("down step not minus one");
    count_hold_a: assert property (!ref_step_valid |-> $stable(ref_count))
        else $error("count moved without a step");
    inhib_block_a: assert property (inhib_held |=> !ref_step_valid)
        else $error("step while inhibited");
    inactive_quiet_a: assert property (idle_held |-> !ref_step_valid)
        else $error("step outside position mode");
    err_clear_a: assert property ($fell(pulse_input_overrate_error) |->
        $past(stat_clr)) else $error("error cleared without a write");
    err_active_a: assert property ($rose(pulse_input_overrate_error) |->
        position_mode_active) else $error("error raised while idle");
endmodule
bind pprf_top pprf_checker #(.FREQ_WIN_CYC(FREQ_WIN_CYC)) i_pprf_checker (.clk(clk),
    .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .position_ref_inhibit_input(position_ref_inhibit_input),
    .position_mode_active(position_mode_active), .ref_step_valid(ref_step_valid),
    .pulse_input_overrate_error(pulse_input_overrate_error), .ref_step_up(ref_step_up),
    .ref_count(ref_count));

/* testbench/pprf_pulse_gen.sv */
// pulse source model standing in for the host pulse generator
`timescale 1ns/1ps
module pprf_pulse_gen (
    input wire logic clk,
    output pprf_pkg::pprf_pins_t ls,
    output pprf_pkg::pprf_pins_t hs_p,
    output pprf_pkg::pprf_pins_t hs_n
);
    // ------------------------------------------------------------
    // pins idle low, differential pairs firmly low
    // ------------------------------------------------------------
    initial begin
        ls = '0;
        hs_p = '0;
        hs_n = '1;
    end
    task automatic put(input logic hs, input pprf_pkg::pprf_pins_t p, input int w);
        @(posedge clk);
        if (hs) begin
            hs_p <= p;
            hs_n <= ~p;
        end else begin
            ls <= p;
        end
        repeat (w - 1) @(posedge clk);
    endtask
    // n counted units in form f; always ends at 00 so forms can switch
    task automatic move(input logic [1:0] f, input logic hs, input logic up, input int n,
        input int w);
        logic d;
        logic [1:0] qi;
        d = up ^ (f == 2'h1);
        qi = 2'h0;
        put(hs, {1'b0, d & ~f[1]}, w);
        for (int i = 0; i < n; i++) begin
            if (f == 2'h2) begin
                qi = up ? qi + 2'h1 : qi - 2'h1;
                put(hs, {qi[0] ^ qi[1], qi[1]}, w);
            end else if (f == 2'h3) begin
                put(hs, {up, ~up}, w);
                put(hs, 2'b00, w);
            end else begin
                put(hs, {1'b1, d}, w);
                put(hs, {1'b0, d}, w);
            end
        end
        put(hs, 2'b00, w);
    endtask
endmodule

/* testbench/pprf_tb_top.sv */
// self-checking bench for the pulse reference front end
`timescale 1ns/1ps
module pprf_tb_top;
    typedef struct packed {
        logic [1:0] form;
        logic rot;
        logic hs;
        logic up;
        logic [3:0] n;
        logic signed [4:0] d;
    } pprf_row_t;
    // ------------------------------------------------------------
    // stimulus tables: form, rot, group, dir, units, count delta
    // ------------------------------------------------------------
    localparam pprf_row_t ROWS [9] = '{'{2'h0, 1'b0, 1'b0, 1'b1, 4'h3, 5'h03},
        '{2'h0, 1'b0, 1'b1, 1'b0, 4'h2, 5'h1E}, '{2'h1, 1'b0, 1'b0, 1'b1, 4'h2, 5'h02},
        '{2'h1, 1'b1, 1'b1, 1'b0, 4'h3, 5'h03}, '{2'h2, 1'b0, 1'b0, 1'b1, 4'h8, 5'h08},
        '{2'h2, 1'b0, 1'b1, 1'b0, 4'h4, 5'h1C}, '{2'h2, 1'b1, 1'b0, 1'b1, 4'h4, 5'h1C},
        '{2'h3, 1'b0, 1'b1, 1'b1, 4'h2, 5'h02}, '{2'h3, 1'b1, 1'b0, 1'b0, 4'h3, 5'h03}};
    localparam logic [5:0] RA [7] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h3C};
    localparam logic [31:0] RV [7] = '{32'h0, 32'h1E, 32'h5, 32'h1F40, 32'h1, 32'h1, 32'h0};
    localparam logic [31:0] CT [3] = '{32'h0, 32'h11, 32'h1};
    // filter cycles at 10 ns for settings 4 and 3, rounded up
    localparam int FT [2] = '{(4 * 25 + 9) / 10, (3 * 25 + 9) / 10};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic inh = 1'b0;
    logic [31:0] q;
    wire logic [31:0] rdata, ref_count, enc_position;
    wire logic avs_waitrequest, pma, err, stv;
    wire pprf_pkg::pprf_pins_t ls, hs_p, hs_n;
    int error_cnt = 0;
    int n_tests = 0;
    int exp_cnt = 0;
    int k;
    pprf_row_t r;
    always #5 clk = ~clk;
    pprf_top #(.FREQ_WIN_CYC(200)) i_pprf_top (.clk(clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(rdata),
        .avs_waitrequest(avs_waitrequest), .ls_pulse(ls.pulse), .ls_direction(ls.dir),
        .high_speed_pulse_pos(hs_p.pulse), .high_speed_pulse_neg(hs_n.pulse),
        .high_speed_direction_pos(hs_p.dir), .high_speed_direction_neg(hs_n.dir),
        .position_ref_inhibit_input(inh), .position_mode_active(pma),
        .pulse_input_overrate_error(err), .ref_step_valid(stv), .ref_step_up(),
        .ref_count(ref_count), .enc_position(enc_position));
    pprf_pulse_gen i_pprf_pulse_gen (.clk(clk), .ls(ls), .hs_p(hs_p), .hs_n(hs_n));
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        // hold until wait drops; a dead slave is left to the watchdog
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            error_cnt++;
        end
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic final_report;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog, well beyond the few thousand cycles the run needs
    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        final_report;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(RA[i], RV[i]);
        bus(1'b1, 6'h3C, 32'hFFFF);
        rd_chk(6'h3C, 32'h0);
        bus(1'b1, 6'h1C, 32'h55);
        rd_chk(6'h1C, 32'h0);
        bus(1'b1, 6'h10, 32'h3);
        bus(1'b1, 6'h14, 32'h2);
        bus(1'b1, 6'h04, 32'h4);
        bus(1'b1, 6'h08, 32'h3);
        // per group: glitch one cycle short is dropped, then exact lag
        for (int g = 0; g < 2; g++) begin
            bus(1'b1, 6'h00, 32'h1 | (32'(g) << 8));
            // levels kept at least four filter times, only the glitch is short
            i_pprf_pulse_gen.put(g[0], 2'b01, 40);
            i_pprf_pulse_gen.put(g[0], 2'b11, FT[g] - 1);
            i_pprf_pulse_gen.put(g[0], 2'b01, 40);
            i_pprf_pulse_gen.put(g[0], 2'b11, 1);
            k = 0;
            do begin
                @(posedge clk);
                #1;
                k++;
            end while (stv !== 1'b1 && k < 40);
            chk(32'(k), 32'(FT[g] + 1));
            repeat (30) @(posedge clk);
            i_pprf_pulse_gen.put(g[0], 2'b00, 40);
            exp_cnt++;
            chk(ref_count, 32'(exp_cnt));
        end
        bus(1'b1, 6'h04, 32'h2);
        bus(1'b1, 6'h08, 32'h1);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            bus(1'b1, 6'h00, {15'h0, r.rot, 2'h0, r.form, 3'h0, r.hs, 8'h01});
            i_pprf_pulse_gen.move(r.form, r.hs, r.up, int'(r.n), 20);
            exp_cnt += int'(r.d);
            chk(ref_count, 32'(exp_cnt));
            chk(enc_position, 32'(exp_cnt * 3 / 2));
        end
        // idle mode, other source, then inhibit: no counts move
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, 6'h00, CT[m]);
            inh <= (m == 2);
            i_pprf_pulse_gen.move(2'h0, 1'b0, 1'b1, 2, 20);
            chk(ref_count, 32'(exp_cnt));
            chk({31'h0, pma}, 32'(m == 2));
        end
        inh <= 1'b0;
        chk({31'h0, err}, 32'h0);
        bus(1'b1, 6'h0C, 32'h3);
        i_pprf_pulse_gen.move(2'h0, 1'b0, 1'b1, 8, 20);
        exp_cnt += 8;
        chk({31'h0, err}, 32'h1);
        repeat (250) @(posedge clk);
        rd_chk(6'h18, 32'h3);
        bus(1'b1, 6'h18, 32'h1);
        rd_chk(6'h18, 32'h2);
        chk(ref_count, 32'(exp_cnt));
        // mid-run reset clears counts and flags, returns configuration to reset values
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(ref_count | enc_position, 32'h0);
        chk({30'h0, pma, err}, 32'h0);
        reset_n <= 1'b1;
        rd_chk(6'h04, 32'h1E);
        rd_chk(6'h00, 32'h0);
        final_report;
    end
endmodule
